// ===== logic/dmr_mode_regs.sv
/*
  Device-side mode register decode, field outputs and DLL state tracking.
  Assumes command pins are synchronous to clk; array storage lives elsewhere.
*/
`timescale 1ns/10ps
module dmr_mode_regs
  import dmr_pkg::*;
#(
  parameter int LOCK_CYC = DLL_LOCK_CYC
) (
  input  wire logic              clk,          // device clock
  input  wire logic              nrst,         // async reset, active low
  input  wire logic              cke,          // clock enable pin
  input  wire logic              csN,          // chip select, active low
  input  wire logic              rasN,         // row strobe, active low
  input  wire logic              casN,         // column strobe, active low
  input  wire logic              weN,          // write enable, active low
  input  wire logic [BANK_W-1:0] bank,         // bank address
  input  wire logic [ADDR_W-1:0] addr,         // address / register data
  output logic [2:0]             burstLen,     // burst length code
  output logic                   burstType,    // interleaved when high
  output logic [2:0]             casLat,       // CAS latency code
  output logic                   testMode,     // test mode bit
  output logic [2:0]             wrRecovery,   // write recovery code
  output logic                   mrValid,      // main register programmed
  output logic                   dllOn,        // DLL enabled
  output logic                   dllLocked,    // lock wait elapsed
  output logic                   reducedDrive, // reduced strength driver
  output logic [2:0]             addLat,       // additive latency
  output logic [1:0]             termSel,      // termination setting {A6,A2}
  output logic [2:0]             ocdMode,      // calibration control
  output logic                   strobeNDis,   // complementary strobe off
  output logic                   selfRefresh,  // in self refresh
  output logic                   readEarly     // read seen before lock
);
  logic             selected;
  logic             mrsCmd;
  logic             mrWrite;
  logic             e1Write;
  logic             dllResetReq;
  logic             srEntry;
  logic             srExit;
  logic             readCmd;
  logic             next_dllOn;
  logic             lockRestart;
  logic [LOCK_W-1:0] lockCnt;
  logic [LOCK_W-1:0] next_lockCnt;

  // chip select is part of the command code
  assign selected    = ~csN;
  assign mrsCmd      = selected & cke & ({rasN, casN, weN} == CMD_MRS);
  assign mrWrite     = mrsCmd & (bank == BANK_MR);
  assign e1Write     = mrsCmd & (bank == BANK_EMR1);
  // refresh with clock enable low enters self refresh
  assign srEntry     = ~selfRefresh & selected & ~cke & ({rasN, casN, weN} == CMD_REFRESH);
  // exit is marked by clock enable rising again
  assign srExit      = selfRefresh & cke;
  assign dllResetReq = (mrWrite & addr[MR_DLLRST]) | srExit;
  assign readCmd     = selected & cke & ({rasN, casN, weN} == CMD_READ);
  // self refresh wins over a register write on the same edge
  assign next_dllOn  = srEntry ? 1'b0 :
                       srExit  ? 1'b1 :
                       e1Write ? ~addr[E1_DLLDIS] : dllOn;
  // counter idles at zero while the DLL is off, so enabling alone reports lock only after the full LOCK_CYC count
  assign lockRestart = dllResetReq | ~next_dllOn;
  assign next_lockCnt = lockRestart ? LOCK_W'(0) :
                        (lockCnt != LOCK_W'(LOCK_CYC)) ? lockCnt + LOCK_W'(1) : lockCnt;

  // fields reset to zero only for a known sim value; mrValid marks undefined
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      burstLen   <= 3'h0;
      burstType  <= 1'b0;
      casLat     <= 3'h0;
      testMode   <= 1'b0;
      wrRecovery <= 3'h0;
      mrValid    <= 1'b0;
    end else if (mrWrite) begin
      burstLen   <= addr[MR_BL_LO +: 3];
      burstType  <= addr[MR_BT];
      casLat     <= addr[MR_CL_LO +: 3];
      testMode   <= addr[MR_TM];
      wrRecovery <= addr[MR_WR_LO +: 3];
      mrValid    <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reducedDrive <= 1'b0;
      addLat       <= 3'h0;
      termSel      <= 2'h0;
      ocdMode      <= OCD_EXIT;
      strobeNDis   <= 1'b0;
    end else if (e1Write) begin
      reducedDrive <= addr[E1_DRV];
      // adjust mode keeps the previous additive latency inside the device
      if (addr[E1_OCD_LO +: 3] != OCD_ADJUST)
        addLat <= addr[E1_AL_LO +: 3];
      termSel      <= {addr[E1_RTT1], addr[E1_RTT0]};
      ocdMode      <= addr[E1_OCD_LO +: 3];
      strobeNDis   <= addr[E1_NDQS];
    end
  end

  // array is never touched here, so re-initialising is data safe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      selfRefresh <= 1'b0;
      dllOn       <= 1'b0;
      lockCnt     <= LOCK_W'(0);
      dllLocked   <= 1'b0;
      readEarly   <= 1'b0;
    end else begin
      if (srEntry)
        selfRefresh <= 1'b1;
      else if (srExit)
        selfRefresh <= 1'b0;
      dllOn     <= next_dllOn;
      lockCnt   <= next_lockCnt;
      dllLocked <= next_dllOn & ~lockRestart & (next_lockCnt == LOCK_W'(LOCK_CYC));
      // only flags an early read; the read itself is never blocked
      readEarly <= readCmd & ~dllLocked;
    end
  end

  property p_mr_capture;
    @(posedge clk) disable iff (!nrst)
      mrWrite |=> (casLat == $past(addr[MR_CL_LO +: 3])) && mrValid;
  endproperty
  a_mr_capture: assert property (p_mr_capture) else $error("mode register not captured");

  property p_cs_mask;
    @(posedge clk) disable iff (!nrst)
      csN |=> $stable(casLat) && $stable(addLat);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command acted while deselected");

  property p_sr_dll_off;
    @(posedge clk) disable iff (!nrst)
      srEntry |=> !dllOn && selfRefresh;
  endproperty
  a_sr_dll_off: assert property (p_sr_dll_off) else $error("dll still on in self refresh");

  property p_sr_dll_back;
    @(posedge clk) disable iff (!nrst)
      srExit |=> dllOn && !dllLocked;
  endproperty
  a_sr_dll_back: assert property (p_sr_dll_back) else $error("dll not reset on exit");

  property p_lock_wait;
    @(posedge clk) disable iff (!nrst)
      (mrWrite && addr[MR_DLLRST]) |=> !dllLocked [*8];
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock asserted too early");

  property p_e1_fields;
    @(posedge clk) disable iff (!nrst)
      e1Write |=> (ocdMode == $past(addr[E1_OCD_LO +: 3])) && (strobeNDis == $past(addr[E1_NDQS]));
  endproperty
  a_e1_fields: assert property (p_e1_fields) else $error("extended register 1 not captured");

  property p_wr_field;
    @(posedge clk) disable iff (!nrst)
      mrWrite |=> (wrRecovery == $past(addr[MR_WR_LO +: 3])) && (burstLen == $past(addr[MR_BL_LO +: 3]));
  endproperty
  a_wr_field: assert property (p_wr_field) else $error("recovery field wrong");

  property p_unprog;
    @(posedge clk) disable iff (!nrst)
      !mrValid |=> !mrValid || $past(mrWrite);
  endproperty
  a_unprog: assert property (p_unprog) else $error("register valid without write");

  property p_cke_mask;
    @(posedge clk) disable iff (!nrst)
      (selected && !cke && ({rasN, casN, weN} == CMD_MRS)) |=> $stable(casLat) && $stable(burstLen);
  endproperty
  a_cke_mask: assert property (p_cke_mask) else $error("register write taken with clock enable low");

  property p_other_bank;
    @(posedge clk) disable iff (!nrst)
      (mrsCmd && (bank != BANK_MR) && (bank != BANK_EMR1)) |=> $stable(casLat) && $stable(addLat);
  endproperty
  a_other_bank: assert property (p_other_bank) else $error("write to another bank changed a field");

  property p_adjust_al;
    @(posedge clk) disable iff (!nrst)
      (e1Write && (addr[E1_OCD_LO +: 3] == OCD_ADJUST)) |=> $stable(addLat);
  endproperty
  a_adjust_al: assert property (p_adjust_al) else $error("additive latency moved in adjust mode");

  property p_al_capture;
    @(posedge clk) disable iff (!nrst)
      (e1Write && (addr[E1_OCD_LO +: 3] != OCD_ADJUST)) |=> (addLat == $past(addr[E1_AL_LO +: 3]));
  endproperty
  a_al_capture: assert property (p_al_capture) else $error("additive latency not captured");

  property p_read_early;
    @(posedge clk) disable iff (!nrst)
      (readCmd && !dllLocked) |=> readEarly;
  endproperty
  a_read_early: assert property (p_read_early) else $error("early read not flagged");

  property p_locked_count;
    @(posedge clk) disable iff (!nrst)
      dllLocked |-> dllOn && (lockCnt == LOCK_W'(LOCK_CYC));
  endproperty
  a_locked_count: assert property (p_locked_count) else $error("lock shown before the full count");

  property p_lock_reach;
    @(posedge clk) disable iff (!nrst)
      (dllOn && !srEntry && !dllResetReq && !(e1Write && addr[E1_DLLDIS]) && (lockCnt == LOCK_W'(LOCK_CYC - 1)))
        |=> dllLocked;
  endproperty
  a_lock_reach: assert property (p_lock_reach) else $error("lock not shown at the end of the count");

  property p_sr_hold;
    @(posedge clk) disable iff (!nrst)
      (selfRefresh && !cke) |=> selfRefresh && !dllOn && !dllLocked;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self refresh state not held");
endmodule

// ===== logic/dmr_pkg.sv
/*
  Constants for the DDR2 device-side mode register and DLL control block.
  Assumes one 50 MHz clock and command pins already sampled on it.

// What this block does
// - main register write: cs, ras, cas, we low, bank zero, A12..A0 data
// - register writes and DLL reset leave array contents untouched
// - main register is undefined until programmed
// - main fields: burst length, type, CAS latency, test, DLL reset, recovery
// - extended 1 fields: DLL, drive, additive latency, calibration, strobe, termination
// - DLL disabled on self refresh entry, re-enabled and reset on exit
// - commands masked while chip select is high
*/
package dmr_pkg;
  localparam int        ADDR_W       = 13;
  localparam int        BANK_W       = 3;
  localparam logic [2:0] BANK_MR     = 3'h0;
  localparam logic [2:0] BANK_EMR1   = 3'h1;
  localparam logic [2:0] BANK_EMR2   = 3'h2;
  localparam logic [2:0] BANK_EMR3   = 3'h3;
  localparam int        DLL_LOCK_CYC = 200;
  localparam int        LOCK_W       = 8;
  // mode register fields
  localparam int        MR_BL_LO  = 0;
  localparam int        MR_BT     = 3;
  localparam int        MR_CL_LO  = 4;
  localparam int        MR_TM     = 7;
  localparam int        MR_DLLRST = 8;
  localparam int        MR_WR_LO  = 9;
  // extended register 1 fields
  localparam int        E1_DLLDIS = 0;
  localparam int        E1_DRV    = 1;
  localparam int        E1_RTT0   = 2;
  localparam int        E1_AL_LO  = 3;
  localparam int        E1_RTT1   = 6;
  localparam int        E1_OCD_LO = 7;
  localparam int        E1_NDQS   = 10;
  localparam logic [2:0] OCD_EXIT    = 3'h0;
  localparam logic [2:0] OCD_ADJUST  = 3'h4;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;
  // command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS     = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_READ    = 3'h5;
endpackage

// ===== testbench/dmr_ctrl_model.sv
/* Controller-side model: drives the command pins of the mode register block.
   Assumes one caller at a time; clock comes from the bench. */
`timescale 1ns/10ps
module dmr_ctrl_model
  import dmr_pkg::*;
(
  input  wire logic              clk,  // device clock
  output logic                   cke,  // clock enable
  output logic                   csN,  // chip select, active low
  output logic                   rasN, // row strobe, active low
  output logic                   casN, // column strobe, active low
  output logic                   weN,  // write enable, active low
  output logic [BANK_W-1:0]      bank, // bank address
  output logic [ADDR_W-1:0]      addr  // address bits
);
  localparam int STABLE_CYC = 10000; // 200 us of 20 ns clocks
  logic initDone;                    // sequence finished, traffic may start
  initial begin
    cke = 1'b0;
    csN = 1'b1;
    {rasN, casN, weN} = 3'h7;
    bank = 3'h0;
    addr = 13'h0000;
    initDone = 1'b0;
  end
  // one-cycle command, then deselect with the lines no longer holding their value
  task op(input logic c, input logic s, input logic [2:0] k, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    #1 {cke, csN, rasN, casN, weN, bank, addr} = {c, s, k, b, a};
    @(posedge clk);
    #1 {csN, rasN, casN, weN, bank, addr} = {4'hf, ~b, ~a};
  endtask
  task wake();
    @(posedge clk);
    #1 cke = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task init_seq(input logic [ADDR_W-1:0] e1, input logic [ADDR_W-1:0] mr);
    repeat (STABLE_CYC) @(posedge clk);
    #1 cke = 1'b1;
    repeat (20) @(posedge clk);
    op(1'b1, 1'b0, 3'h2, 3'h0, 13'h0400);
    op(1'b1, 1'b0, CMD_MRS, BANK_EMR2, 13'h0000);
    op(1'b1, 1'b0, CMD_MRS, BANK_EMR3, 13'h0000);
    op(1'b1, 1'b0, CMD_MRS, BANK_EMR1, e1 & 13'h1c7e);
    op(1'b1, 1'b0, CMD_MRS, BANK_MR, mr | 13'h0100);
    op(1'b1, 1'b0, 3'h2, 3'h0, 13'h0400);
    repeat (2) op(1'b1, 1'b0, CMD_REFRESH, 3'h0, 13'h0000);
    op(1'b1, 1'b0, CMD_MRS, BANK_MR, mr & 13'h1eff);
    initDone = 1'b1;
  endtask
endmodule

// ===== testbench/dmr_mode_regs_test.sv
/* Bench for the mode register block: init, masking, DLL lock, calibration, self refresh.
   Assumes the controller model owns every command pin. */
`timescale 1ns/10ps
module dmr_mode_regs_test
  import dmr_pkg::*;
;
  localparam int LC = 16;
  localparam logic [12:0] MRW = 13'h0a5b; // wr 5, cl 5, interleaved, burst code 3
  localparam logic [12:0] E1W = 13'h0416; // strobe off, al 2, term 1, reduced drive
  logic clk = 1'b0, nrst = 1'b0, cke, csN, rasN, casN, weN, burstType, testMode, mrValid, dllOn;
  logic dllLocked, reducedDrive, strobeNDis, selfRefresh, readEarly;
  logic [2:0] bank, burstLen, casLat, wrRecovery, addLat, ocdMode;
  logic [12:0] addr;
  logic [1:0] termSel;
  int mismatches = 0, num_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  dmr_ctrl_model dmr_ctrl_model_inst (.clk, .cke, .csN, .rasN, .casN, .weN, .bank, .addr);
  dmr_mode_regs #(.LOCK_CYC(LC)) dmr_mode_regs_inst (.clk, .nrst, .cke, .csN, .rasN, .casN, .weN, .bank,
    .addr, .burstLen, .burstType, .casLat, .testMode, .wrRecovery, .mrValid, .dllOn, .dllLocked,
    .reducedDrive, .addLat, .termSel, .ocdMode, .strobeNDis, .selfRefresh, .readEarly);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [2:0] b, input logic [12:0] a);
    dmr_ctrl_model_inst.op(1'b1, 1'b0, CMD_MRS, b, a);
  endtask
  task t_init();
    chk("mrValid", 0, mrValid);
    dmr_ctrl_model_inst.init_seq(E1W, MRW);
    chk("fields", {5'h0, 3'h3, 1'b1, 3'h5, 1'b0, 3'h5}, {burstLen, burstType, casLat, testMode, wrRecovery});
    chk("mrValid", 1, mrValid);
    chk("ext1", {5'h0, 1'b1, 1'b1, 3'h2, 2'h1, 3'h0, 1'b1}, {dllOn, reducedDrive, addLat, termSel, ocdMode, strobeNDis});
  endtask
  task t_mask();
    dmr_ctrl_model_inst.op(1'b1, 1'b1, CMD_MRS, BANK_MR, 13'h0000);
    chk("burstLen", 3'h3, burstLen);
    dmr_ctrl_model_inst.op(1'b0, 1'b0, CMD_MRS, BANK_MR, 13'h0000);
    chk("burstLen", 3'h3, burstLen);
  endtask
  task t_lock();
    chk("initDone", 1, dmr_ctrl_model_inst.initDone);
    wr(BANK_MR, MRW | 13'h0100);
    dmr_ctrl_model_inst.op(1'b1, 1'b0, CMD_READ, BANK_MR, 13'h0000);
    chk("readEarly", 1, readEarly);
    chk("dllLocked", 0, dllLocked);
    repeat (LC) @(posedge clk);
    #1;
    chk("dllLocked", 1, dllLocked);
  endtask
  task t_cal();
    repeat (DLL_LOCK_CYC) @(posedge clk);
    wr(BANK_EMR1, E1W | 13'h0380);
    chk("ocdMode", OCD_DEFAULT, ocdMode);
    wr(BANK_EMR1, E1W);
    chk("exitDefault", {OCD_EXIT, 3'h2}, {ocdMode, addLat});
    wr(BANK_EMR1, E1W | 13'h0200);
    chk("adjustKept", {OCD_ADJUST, 3'h2}, {ocdMode, addLat});
    wr(BANK_EMR1, E1W);
    chk("exitAdjust", {OCD_EXIT, 3'h2}, {ocdMode, addLat});
    wr(BANK_EMR1, (E1W & 13'h1fc7) | 13'h0228);
    chk("adjust", {OCD_ADJUST, 3'h2}, {ocdMode, addLat});
    wr(BANK_EMR1, E1W);
    chk("exit", {OCD_EXIT, 3'h2}, {ocdMode, addLat});
  endtask
  task t_sref();
    dmr_ctrl_model_inst.op(1'b0, 1'b0, CMD_REFRESH, 3'h0, 13'h0000);
    chk("enter", 2'h2, {selfRefresh, dllOn});
    dmr_ctrl_model_inst.wake();
    chk("exit", 3'h2, {selfRefresh, dllOn, dllLocked});
  endtask
  // ceiling sits well above the roughly 10,300 cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    t_init();
    t_mask();
    t_lock();
    t_cal();
    t_sref();
    tally_and_finish();
  end
endmodule
